/* dpi_pkg.sv */
// constants, layouts and carrier types for the differential protection
// inrush blocking decision block; no surrounding state is assumed.
package dpi_pkg;

    localparam int DPI_NPH = 3;

    // register byte addresses on the plain register port
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_PICKUP = 8'h04;
    localparam logic [7:0] A_SLOPE1 = 8'h08;
    localparam logic [7:0] A_BREAK  = 8'h0C;
    localparam logic [7:0] A_SLOPE2 = 8'h10;
    localparam logic [7:0] A_HS1    = 8'h14;
    localparam logic [7:0] A_HS2    = 8'h18;
    localparam logic [7:0] A_H2PCT  = 8'h1C;
    localparam logic [7:0] A_H5PCT  = 8'h20;
    localparam logic [7:0] A_REACT  = 8'h24;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam logic [7:0] A_HS1EFF = 8'h2C;

    // control register bit positions
    localparam int C_DIFF_EN  = 0;
    localparam int C_SIMPLE   = 1;
    localparam int C_H2_EN    = 2;
    localparam int C_CROSS    = 3;
    localparam int C_SATGAP   = 4;
    localparam int C_H5_EN    = 5;
    localparam int C_HS2_EN   = 6;
    localparam int C_WIDTH    = 7;

    // reset values; currents in 0.01 pu, slopes and ratios in percent,
    // reactance in 0.01 percent
    localparam logic [6:0]  CTRL_RST   = 7'h3D;
    localparam logic [15:0] PICKUP_RST = 16'h0014;
    localparam logic [7:0]  SLOPE1_RST = 8'h1E;
    localparam logic [15:0] BREAK_RST  = 16'h0064;
    localparam logic [7:0]  SLOPE2_RST = 8'h50;
    localparam logic [15:0] HS1_RST    = 16'h03E8;
    localparam logic [15:0] HS2_RST    = 16'h03E8;
    localparam logic [7:0]  H2PCT_RST  = 8'h14;
    localparam logic [7:0]  H5PCT_RST  = 8'h23;
    localparam logic [15:0] REACT_RST  = 16'h03E8;

    // setting limits in 0.01 pu
    localparam logic [15:0] PICKUP_MIN = 16'h000A;
    localparam logic [15:0] PICKUP_MAX = 16'h00FA;
    localparam logic [15:0] HS_MIN     = 16'h00FA;
    localparam logic [15:0] HS_MAX     = 16'h0C80;

    // one over reactance: 100 (0.01 pu) times 10000 (0.01 percent)
    localparam logic [19:0] AUTO_NUM   = 20'hF4240;
    localparam logic [4:0]  DIV_LAST   = 5'h13;
    localparam logic [31:0] PCT_SCALE  = 32'h0000_0064;

    typedef struct packed {
        logic [15:0]       fund;
        logic [15:0]       h2;
        logic [15:0]       h5;
        logic [2:0][15:0]  wind;
        logic              satgap;
    } dpi_meas_s;

    typedef struct packed {
        logic [15:0] is1;
        logic [7:0]  k1;
        logic [15:0] is2;
        logic [7:0]  k2;
        logic [15:0] hs1;
        logic [15:0] hs2;
        logic [7:0]  h2pct;
        logic [7:0]  h5pct;
    } dpi_cfg_s;

    typedef struct packed {
        logic lowop;
        logic h2det;
        logic h5det;
        logic hs1;
        logic hs2;
    } dpi_res_s;

endpackage

/* dpi_phase.sv */
// single-phase evaluation: bias, operating characteristic, harmonic
// ratios and high-set comparisons. purely combinational; the caller
// registers the result once per measurement update.
`timescale 1ns/10ps
module dpi_phase
    import dpi_pkg::*;
(
    input  wire dpi_meas_s meas,
    input  wire dpi_cfg_s  cfg,
    output wire dpi_res_s  res
);
    wire [17:0] wsum;
    wire [16:0] bias;
    wire        above_brk;
    wire [31:0] idiff100;
    wire [31:0] is1_100;
    wire [31:0] k1b;
    wire [31:0] seg3;
    wire [31:0] slope_op;
    wire [31:0] op100;

    // half the sum of corrected winding magnitudes
    assign wsum = 18'(meas.wind[0]) + 18'(meas.wind[1])
                + 18'(meas.wind[2]);
    assign bias = wsum[17:1];

    // scaled by 100 so percent slopes need no division
    assign idiff100  = 32'(meas.fund) * PCT_SCALE;
    assign is1_100   = 32'(cfg.is1) * PCT_SCALE;
    assign above_brk = bias > 17'(cfg.is2);
    assign k1b       = 32'(cfg.k1) * 32'(bias);
    // second slope only past the break point
    assign seg3      = 32'(cfg.k1) * 32'(cfg.is2)
                     + 32'(cfg.k2) * 32'(bias - 17'(cfg.is2));
    assign slope_op  = above_brk ? seg3 : k1b;
    // flat at pickup until a slope rises above it
    assign op100     = (slope_op > is1_100) ? slope_op : is1_100;

    assign res.lowop = idiff100 > op100;
    // ratio of harmonic to fundamental against a percentage
    assign res.h2det = 32'(meas.h2) * PCT_SCALE
                     > 32'(cfg.h2pct) * 32'(meas.fund);
    assign res.h5det = 32'(meas.h5) * PCT_SCALE
                     > 32'(cfg.h5pct) * 32'(meas.fund);
    // fundamental only, no restraint
    assign res.hs1   = meas.fund > cfg.hs1;
    assign res.hs2   = meas.fund > cfg.hs2;

endmodule

/* dpi_core.sv */
// top of the inrush blocking decision block: register file, automatic
// high-set divider, cross-phase blocking and registered trip outputs.
// assumes measurements arrive synchronous to clock with a one-cycle
// valid strobe, already ratio, vector and zero-sequence corrected.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
// How it works
// - per phase, harmonic over fundamental ratio formed
// - ratio above threshold blocks low-set element
// - cross blocking spreads one detection to all
// - without cross, only detecting phase blocked
// - no harmonic blocking above either high-set
// - saturation detector has only an enable
// - saturation/no-gap releases second-harmonic blocking
// - two high-set elements never harmonic blocked
// - high-set thresholds limited to 2.5..32 pu
// - second high-set uses unrestrained fundamental
// - simple mode: first high-set is 1/reactance
// - pickup 0.1..2.5 pu in 0.01 steps
// - blocking only when its enable is set
// - fifth harmonic blocks per phase, no cross
// - characteristic flat at pickup at low bias
// - first slope programmable percent, 30 advised
// - second slope above break point, 80 advised
// - three-segment operate threshold from bias
// - bias is half the winding magnitude sum
module dpi_core
    import dpi_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    input  wire logic                     meas_valid,
    input  wire dpi_meas_s [DPI_NPH-1:0]  meas,
    output logic                          res_valid,
    output logic      [DPI_NPH-1:0]       lowset_trip,
    output logic      [DPI_NPH-1:0]       h2_block,
    output logic      [DPI_NPH-1:0]       h5_block,
    output logic      [DPI_NPH-1:0]       hs1_trip,
    output logic      [DPI_NPH-1:0]       hs2_trip,
    output logic                          any_trip
);
    logic [C_WIDTH-1:0] ctrl_r;
    logic [15:0]        is1_r;
    logic [7:0]         k1_r;
    logic [15:0]        is2_r;
    logic [7:0]         k2_r;
    logic [15:0]        hs1_r;
    logic [15:0]        hs2_r;
    logic [7:0]         h2pct_r;
    logic [7:0]         h5pct_r;
    logic [15:0]        react_r;
    logic [15:0]        auto_r;
    logic [19:0]        dnum_r;
    logic [15:0]        drem_r;
    logic [19:0]        dquo_r;
    logic [4:0]         dcnt_r;
    logic               dbusy_r;
    logic [DPI_NPH-1:0] hsov_r;

    function automatic logic [15:0] clamp16(input logic [19:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [15:0] r;
        if (v < 20'(lo))
            r = lo;
        else if (v > 20'(hi))
            r = hi;
        else
            r = v[15:0];
        return r;
    endfunction

    // ---------------- register decode ----------------
    wire wr_ctrl   = reg_wr && (reg_addr == A_CTRL);
    wire wr_pickup = reg_wr && (reg_addr == A_PICKUP);
    wire wr_slope1 = reg_wr && (reg_addr == A_SLOPE1);
    wire wr_break  = reg_wr && (reg_addr == A_BREAK);
    wire wr_slope2 = reg_wr && (reg_addr == A_SLOPE2);
    wire wr_hs1    = reg_wr && (reg_addr == A_HS1);
    wire wr_hs2    = reg_wr && (reg_addr == A_HS2);
    wire wr_h2pct  = reg_wr && (reg_addr == A_H2PCT);
    wire wr_h5pct  = reg_wr && (reg_addr == A_H5PCT);
    wire wr_react  = reg_wr && (reg_addr == A_REACT);

    wire diff_en   = ctrl_r[C_DIFF_EN];
    wire simple_md = ctrl_r[C_SIMPLE];
    wire h2_en     = ctrl_r[C_H2_EN];
    wire cross_en  = ctrl_r[C_CROSS];
    // the detector itself has no setting besides this bit
    wire satgap_en = ctrl_r[C_SATGAP];
    wire h5_en     = ctrl_r[C_H5_EN];
    wire hs2_en    = ctrl_r[C_HS2_EN];

    // out-of-range writes are clamped, not rejected
    wire [15:0] pickup_in = clamp16(reg_wdata[19:0] & {4'h0, 16'hFFFF},
                                    PICKUP_MIN, PICKUP_MAX);
    wire [15:0] hs_in     = clamp16({4'h0, reg_wdata[15:0]},
                                    HS_MIN, HS_MAX);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r  <= CTRL_RST;
            is1_r   <= PICKUP_RST;
            k1_r    <= SLOPE1_RST;
            is2_r   <= BREAK_RST;
            k2_r    <= SLOPE2_RST;
            hs1_r   <= HS1_RST;
            hs2_r   <= HS2_RST;
            h2pct_r <= H2PCT_RST;
            h5pct_r <= H5PCT_RST;
            react_r <= REACT_RST;
        end
        else
        begin
            if (wr_ctrl)   ctrl_r  <= reg_wdata[C_WIDTH-1:0];
            if (wr_pickup) is1_r   <= pickup_in;
            if (wr_slope1) k1_r    <= reg_wdata[7:0];
            if (wr_break)  is2_r   <= reg_wdata[15:0];
            if (wr_slope2) k2_r    <= reg_wdata[7:0];
            if (wr_hs1)    hs1_r   <= hs_in;
            if (wr_hs2)    hs2_r   <= hs_in;
            if (wr_h2pct)  h2pct_r <= reg_wdata[7:0];
            if (wr_h5pct)  h5pct_r <= reg_wdata[7:0];
            if (wr_react)  react_r <= reg_wdata[15:0];
        end
    end

    // ---------------- automatic first high-set ----------------
    // serial restoring divide: one quotient bit a cycle keeps the
    // area small; the effective threshold lags a reactance write by
    // twenty cycles and keeps its old value meanwhile.
    wire [16:0] dshift = {drem_r, dnum_r[19]};
    wire        dge    = dshift >= 17'(react_r);
    wire [16:0] ddiff  = dshift - 17'(react_r);
    wire        ddone  = dbusy_r && (dcnt_r == DIV_LAST);
    wire [19:0] dquo_f = {dquo_r[18:0], dge};

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            dbusy_r <= 1'b0;
            dnum_r  <= 20'h00000;
            drem_r  <= 16'h0000;
            dquo_r  <= 20'h00000;
            dcnt_r  <= 5'h00;
            auto_r  <= HS1_RST;
        end
        else if (wr_react)
        begin
            dbusy_r <= 1'b1;
            dnum_r  <= AUTO_NUM;
            drem_r  <= 16'h0000;
            dquo_r  <= 20'h00000;
            dcnt_r  <= 5'h00;
        end
        else if (dbusy_r)
        begin
            dnum_r <= {dnum_r[18:0], 1'b0};
            drem_r <= dge ? ddiff[15:0] : dshift[15:0];
            dquo_r <= dquo_f;
            dcnt_r <= dcnt_r + 5'h01;
            if (ddone)
            begin
                dbusy_r <= 1'b0;
                auto_r  <= clamp16(dquo_f, HS_MIN, HS_MAX);
            end
        end
    end

    // simple mode replaces the written threshold
    wire [15:0] hs1_eff = simple_md ? auto_r : hs1_r;

    // ---------------- per-phase evaluation ----------------
    dpi_cfg_s cfg;
    assign cfg.is1   = is1_r;
    assign cfg.k1    = k1_r;
    assign cfg.is2   = is2_r;
    assign cfg.k2    = k2_r;
    assign cfg.hs1   = hs1_eff;
    assign cfg.hs2   = hs2_r;
    assign cfg.h2pct = h2pct_r;
    assign cfg.h5pct = h5pct_r;

    wire [DPI_NPH-1:0] lowop;
    wire [DPI_NPH-1:0] h2det;
    wire [DPI_NPH-1:0] h5det;
    wire [DPI_NPH-1:0] hs1_hit;
    wire [DPI_NPH-1:0] hs2_hit;
    wire [DPI_NPH-1:0] sat_rel;

    genvar g;
    generate
        for (g = 0; g < DPI_NPH; g = g + 1)
        begin : g_ph
            dpi_res_s res;
            dpi_phase u_phase (
                .meas (meas[g]),
                .cfg  (cfg),
                .res  (res)
            );
            assign lowop[g]   = res.lowop;
            assign h2det[g]   = res.h2det;
            assign h5det[g]   = res.h5det;
            assign hs1_hit[g] = res.hs1;
            assign hs2_hit[g] = res.hs2;
            // no-gap release only counts when enabled
            assign sat_rel[g] = satgap_en && meas[g].satgap;
        end
    endgenerate

    // ---------------- blocking decision ----------------
    // a released phase does not feed cross blocking either, so a
    // saturated phase cannot hold the others off
    wire [DPI_NPH-1:0] h2_src  = h2det & ~sat_rel;
    wire [DPI_NPH-1:0] hs_over = hs1_hit | hs2_hit;
    // all phases on any detection, or only the detecting one
    wire [DPI_NPH-1:0] h2_sel  = cross_en ? {DPI_NPH{|h2_src}}
                                          : h2_src;
    // enables gate, high-set overrides
    wire [DPI_NPH-1:0] blk2_nxt = {DPI_NPH{h2_en}} & h2_sel & ~hs_over;
    // fifth harmonic is never crossed
    wire [DPI_NPH-1:0] blk5_nxt = {DPI_NPH{h5_en}} & h5det & ~hs_over;
    wire [DPI_NPH-1:0] low_nxt  = {DPI_NPH{diff_en}} & lowop
                                & ~(blk2_nxt | blk5_nxt);
    // high-sets see no harmonic term at all
    wire [DPI_NPH-1:0] hs1_nxt  = {DPI_NPH{diff_en}} & hs1_hit;
    wire [DPI_NPH-1:0] hs2_nxt  = {DPI_NPH{diff_en && hs2_en}} & hs2_hit;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            res_valid   <= 1'b0;
            lowset_trip <= '0;
            h2_block    <= '0;
            h5_block    <= '0;
            hs1_trip    <= '0;
            hs2_trip    <= '0;
            hsov_r      <= '0;
            any_trip    <= 1'b0;
        end
        else
        begin
            res_valid <= meas_valid;
            if (meas_valid)
            begin
                lowset_trip <= low_nxt;
                h2_block    <= blk2_nxt;
                h5_block    <= blk5_nxt;
                hs1_trip    <= hs1_nxt;
                hs2_trip    <= hs2_nxt;
                hsov_r      <= hs_over;
                any_trip    <= |(low_nxt | hs1_nxt | hs2_nxt);
            end
        end
    end

    // ---------------- read port ----------------
    wire [31:0] status = {15'h0000, dbusy_r, any_trip, hs2_trip,
                          hs1_trip, h5_block, h2_block, lowset_trip};
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            A_CTRL:   rd_mux = {25'h0, ctrl_r};
            A_PICKUP: rd_mux = {16'h0, is1_r};
            A_SLOPE1: rd_mux = {24'h0, k1_r};
            A_BREAK:  rd_mux = {16'h0, is2_r};
            A_SLOPE2: rd_mux = {24'h0, k2_r};
            A_HS1:    rd_mux = {16'h0, hs1_r};
            A_HS2:    rd_mux = {16'h0, hs2_r};
            A_H2PCT:  rd_mux = {24'h0, h2pct_r};
            A_H5PCT:  rd_mux = {24'h0, h5pct_r};
            A_REACT:  rd_mux = {16'h0, react_r};
            A_STATUS: rd_mux = status;
            A_HS1EFF: rd_mux = {16'h0, hs1_eff};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence upd_s;
        meas_valid;
    endsequence

    sequence react_wr_s;
        reg_wr && (reg_addr == A_REACT);
    endsequence

    update_each_a: assert property (
        upd_s |=> res_valid ##1 (res_valid == $past(meas_valid)))
        else $error("result not registered per update");

    cross_all_a: assert property (
        (res_valid && cross_en) |->
            (((h2_block | hsov_r) == 3'h7) || (h2_block == 3'h0)))
        else $error("cross blocking not spread to all phases");

    own_phase_a: assert property (
        (upd_s and (!cross_en && h2_en && h2det == 3'h1 &&
                    sat_rel == 3'h0 && hs_over == 3'h0))
            |=> (h2_block == 3'h1))
        else $error("selective second harmonic block wrong");

    hs_no_block_a: assert property (
        res_valid |-> (((h2_block | h5_block) & hsov_r) == 3'h0))
        else $error("harmonic block above high-set");

    sat_release_a: assert property (
        (upd_s and (sat_rel != 3'h0 && (h2det & ~sat_rel) == 3'h0))
            |=> (h2_block == 3'h0))
        else $error("saturation release ignored");

    hs2_trip_a: assert property (
        (upd_s and (diff_en && hs2_en && meas[0].fund > hs2_r
                    && (h2_en || h5_en)))
            |=> hs2_trip[0] ##1 (hs2_trip[0] || $past(meas_valid)))
        else $error("second high-set did not trip");

    hs_range_a: assert property (
        (hs1_eff >= HS_MIN) && (hs1_eff <= HS_MAX) &&
        (hs2_r >= HS_MIN) && (hs2_r <= HS_MAX))
        else $error("high-set threshold out of range");

    pickup_range_a: assert property (
        (is1_r >= PICKUP_MIN) && (is1_r <= PICKUP_MAX))
        else $error("pickup out of range");

    enable_gate_a: assert property (
        (upd_s and (!h2_en && !h5_en))
            |=> (h2_block == 3'h0) && (h5_block == 3'h0))
        else $error("blocking without enable");

    h5_phase_a: assert property (
        (upd_s and (h5_en && h5det == 3'h2 && hs_over == 3'h0))
            |=> (h5_block == 3'h2))
        else $error("fifth harmonic block not per phase");

    auto_hs1_a: assert property (
        react_wr_s |=> dbusy_r ##20 (!dbusy_r || $past(reg_wr)))
        else $error("reciprocal divider did not finish");

endmodule

/* dpi_front.sv */
// front end model: presents three phase measurements with a one-cycle
// valid strobe whenever the bench asks for an update.
// assumes send is a one-cycle pulse with next_meas beside it.
`timescale 1ns/10ps
module dpi_front
    import dpi_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire logic                     send,
    input  wire dpi_meas_s [DPI_NPH-1:0]  next_meas,
    output logic                          meas_valid,
    output dpi_meas_s [DPI_NPH-1:0]       meas
);
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            meas_valid <= 1'b0;
            meas       <= '0;
        end
        else
        begin
            meas_valid <= send;
            // stale data flips every cycle so late sampling cannot pass
            meas       <= send ? next_meas : ~meas;
        end
    end
endmodule

/* tb_dpi_core.sv */
// self-checking bench for the inrush blocking decision block.
// assumes the package and the front end model are compiled first.
`timescale 1ns/10ps
module tb_dpi_core
    import dpi_pkg::*;
;
    logic                    clock;
    logic                    resetn;
    logic [7:0]              reg_addr;
    logic [31:0]             reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [31:0]             reg_rdata;
    logic                    send;
    logic                    meas_valid;
    dpi_meas_s [DPI_NPH-1:0] next_meas;
    dpi_meas_s [DPI_NPH-1:0] meas;
    dpi_meas_s [DPI_NPH-1:0] stim;
    logic                    res_valid;
    logic [DPI_NPH-1:0]      lowset_trip;
    logic [DPI_NPH-1:0]      h2_block;
    logic [DPI_NPH-1:0]      h5_block;
    logic [DPI_NPH-1:0]      hs1_trip;
    logic [DPI_NPH-1:0]      hs2_trip;
    logic                    any_trip;
    int                      mismatches;
    int                      cmp_count;

    dpi_front i_front (.clock(clock), .resetn(resetn), .send(send),
        .next_meas(next_meas), .meas_valid(meas_valid), .meas(meas));

    dpi_core i_dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas(meas),
        .res_valid(res_valid), .lowset_trip(lowset_trip),
        .h2_block(h2_block), .h5_block(h5_block), .hs1_trip(hs1_trip),
        .hs2_trip(hs2_trip), .any_trip(any_trip));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clock);
        #1;
        chk(reg_rdata, 32'h0000_0000);
    endtask

    // bias given directly: two windings carry it, so half their sum is it
    function automatic dpi_meas_s ph(input logic [15:0] f, h2, h5, bias,
                                     input logic sat);
        dpi_meas_s r;
        r.fund   = f;
        r.h2     = h2;
        r.h5     = h5;
        r.wind   = {16'h0000, bias, bias};
        r.satgap = sat;
        return r;
    endfunction

    task automatic apply(input logic [2:0] e_low, e_h2, e_h5, e_hs1, e_hs2);
        @(posedge clock);
        send      <= 1'b1;
        next_meas <= stim;
        @(posedge clock);
        send      <= 1'b0;
        @(posedge clock);
        #1;
        chk(res_valid, 32'h1);
        chk(lowset_trip, e_low);
        chk(h2_block, e_h2);
        chk(h5_block, e_h5);
        chk(hs1_trip, e_hs1);
        chk(hs2_trip, e_hs2);
        chk(any_trip, |(e_low | e_hs1 | e_hs2));
        @(posedge clock);
        #1;
        chk(res_valid, 32'h0);
        chk(lowset_trip, e_low);
    endtask

    task automatic t_regs;
        logic [7:0]  ra [12];
        logic [31:0] rv [12];
        ra = '{A_CTRL, A_PICKUP, A_SLOPE1, A_BREAK, A_SLOPE2, A_HS1, A_HS2,
               A_H2PCT, A_H5PCT, A_REACT, A_HS1EFF, 8'h30};
        rv = '{32'(CTRL_RST), 32'(PICKUP_RST), 32'(SLOPE1_RST),
               32'(BREAK_RST), 32'(SLOPE2_RST), 32'(HS1_RST), 32'(HS2_RST),
               32'(H2PCT_RST), 32'(H5PCT_RST), 32'(REACT_RST),
               32'(HS1_RST), 32'h0000_0000};
        foreach (ra[i])
            rd_chk(ra[i], rv[i]);
        wr(A_PICKUP, 32'h0000_0005);
        rd_chk(A_PICKUP, 32'(PICKUP_MIN));
        wr(A_PICKUP, 32'h0000_012C);
        rd_chk(A_PICKUP, 32'(PICKUP_MAX));
        wr(A_HS1, 32'h0000_0064);
        rd_chk(A_HS1, 32'(HS_MIN));
        wr(A_HS2, 32'h0000_0FA0);
        rd_chk(A_HS2, 32'(HS_MAX));
        wr(A_PICKUP, 32'(PICKUP_RST));
        wr(A_HS1, 32'(HS1_RST));
        wr(A_HS2, 32'(HS2_RST));
    endtask

    // flat, first slope and second slope, each just at and past its line
    task automatic t_slope;
        stim = {ph(16'h006E, '0, '0, 16'h00C8, 1'b0),
                ph(16'h001C, '0, '0, 16'h005A, 1'b0),
                ph(16'h0014, '0, '0, 16'h0032, 1'b0)};
        apply(3'b010, '0, '0, '0, '0);
        stim = {ph(16'h006F, '0, '0, 16'h00C8, 1'b0),
                ph(16'h001B, '0, '0, 16'h005A, 1'b0),
                ph(16'h0015, '0, '0, 16'h0032, 1'b0)};
        apply(3'b101, '0, '0, '0, '0);
    endtask

    task automatic t_h2;
        stim = {ph(16'h0064, '0, '0, '0, 1'b0),
                ph(16'h0064, 16'h0014, '0, '0, 1'b0),
                ph(16'h0064, 16'h0015, '0, '0, 1'b0)};
        apply(3'b000, 3'b111, '0, '0, '0);
        stim[0].satgap = 1'b1;
        apply(3'b111, 3'b000, '0, '0, '0);
        wr(A_CTRL, 32'h0000_0025);
        apply(3'b110, 3'b001, '0, '0, '0);
        stim[0].satgap = 1'b0;
        wr(A_CTRL, 32'h0000_0035);
        apply(3'b110, 3'b001, '0, '0, '0);
        wr(A_CTRL, 32'h0000_0019);
        apply(3'b111, 3'b000, '0, '0, '0);
        wr(A_CTRL, 32'(CTRL_RST));
    endtask

    task automatic t_h5;
        stim = {ph(16'h0064, '0, '0, '0, 1'b0),
                ph(16'h0064, '0, 16'h0024, '0, 1'b0),
                ph(16'h0064, '0, 16'h0023, '0, 1'b0)};
        apply(3'b101, '0, 3'b010, '0, '0);
        wr(A_CTRL, 32'h0000_001D);
        apply(3'b111, '0, '0, '0, '0);
        wr(A_CTRL, 32'(CTRL_RST));
    endtask

    task automatic t_highset;
        stim = {ph('0, '0, '0, '0, 1'b0),
                ph(16'h03E8, 16'h012C, '0, '0, 1'b0),
                ph(16'h03E9, 16'h012C, '0, '0, 1'b0)};
        apply(3'b001, 3'b110, '0, 3'b001, '0);
        wr(A_HS2, 32'h0000_07D0);
        wr(A_CTRL, 32'h0000_007D);
        stim = {ph('0, '0, '0, '0, 1'b0),
                ph(16'h05DC, '0, '0, '0, 1'b0),
                ph(16'h07D1, '0, '0, 16'hFFFF, 1'b0)};
        apply(3'b010, '0, '0, 3'b011, 3'b001);
        wr(A_CTRL, 32'h0000_007C);
        apply('0, '0, '0, '0, '0);
        wr(A_CTRL, 32'(CTRL_RST));
    endtask

    // the divider needs 20 cycles after the reactance write
    task automatic t_simple;
        wr(A_CTRL, 32'h0000_003F);
        wr(A_REACT, 32'h0000_07D0);
        rd_chk(A_STATUS, 32'h0001_0000);
        repeat (22) @(posedge clock);
        rd_chk(A_HS1EFF, 32'h0000_01F4);
        stim = {ph('0, '0, '0, '0, 1'b0),
                ph(16'h01F4, '0, '0, '0, 1'b0),
                ph(16'h01F5, '0, '0, '0, 1'b0)};
        apply(3'b011, '0, '0, 3'b001, '0);
        rd_chk(A_STATUS, 32'h0000_8203);
    endtask

    initial
    begin
        mismatches = 0;
        cmp_count  = 0;
        resetn     = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0000_0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        send       = 1'b0;
        next_meas  = '0;
        stim       = '0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        t_regs;
        t_slope;
        t_h2;
        t_h5;
        t_highset;
        t_simple;
        close_out;
    end

    // the whole sequence needs well under 2000 cycles
    initial
    begin
        #100000;
        mismatches++;
        close_out;
    end
endmodule
